/* File: dac_amp_modulator_unit.sv */
// Dual output unit: AXI4-Lite registers, switch control and two pulse-width modulators.
`timescale 1ns/100ps
module dac_amp_modulator_unit #(
	parameter int STEP_CYCLES = output_unit_pkg::STEP_CYCLES
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// AXI4-Lite write address and data.
	input wire logic [output_unit_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address and data.
	input wire logic [output_unit_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog switch and power controls, one entry per unit.
	output output_unit_pkg::unit_switch_type [1:0] unit_switches,
	// Digital modulator drive of the output pins, one bit per unit.
	output logic [1:0] small_amp_output_pin_out,
	output logic [1:0] small_amp_output_pin_oe,
	output logic [1:0] large_amp_output_pin_out,
	output logic [1:0] large_amp_output_pin_oe
);

	// ----------------------------------------------------------------
	// Elaboration check.
	// ----------------------------------------------------------------
	if (STEP_CYCLES < 1) begin : g_bad_step
		$error("STEP_CYCLES must be at least one");
	end

	// ----------------------------------------------------------------
	// Helper functions.
	// ----------------------------------------------------------------

	// Decodes a byte address into a register index; the low two bits are dropped, so misaligned addresses hit the aligned register.
	function automatic logic [7:0] reg_index(input logic [output_unit_pkg::ADDR_WIDTH-1:0] addr);
		reg_index = 8'(addr >> output_unit_pkg::BYTE_SHIFT);
	endfunction

	// True when the index names a register of the map.
	function automatic logic is_mapped(input logic [7:0] idx);
		is_mapped = (idx == output_unit_pkg::IDX_DATA0) || (idx == output_unit_pkg::IDX_DATA1) ||
			(idx == output_unit_pkg::IDX_CONFIG0) || (idx == output_unit_pkg::IDX_CONFIG1) ||
			(idx == output_unit_pkg::IDX_STATUS) || (idx == output_unit_pkg::IDX_POWER);
	endfunction

	// Merges write data into a 32-bit word under the byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] result;
		result = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				result[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		merge = result;
	endfunction

	// Modulator high count: upper 12 bits plus 2048, i.e. the sign bit inverted.
	function automatic logic [11:0] duty_of(input logic [15:0] word);
		duty_of = word[15 -: output_unit_pkg::DUTY_WIDTH] + output_unit_pkg::DUTY_OFFSET;
	endfunction

	// Switch control for one unit; the DAC claims its amplifier first, the modulator
	// takes the remaining pin, and a free amplifier only runs where no pin is claimed.
	function automatic output_unit_pkg::unit_switch_type route(
		input output_unit_pkg::unit_config_type cfg, input logic [2:0] pwr, input logic [15:0] word);
		output_unit_pkg::unit_switch_type sw;
		logic dac_live;
		logic pwm_small;
		logic pwm_large;
		sw = '0;
		dac_live = cfg.dac_select && pwr[output_unit_pkg::POWER_DAC];
		sw.dac_powered = pwr[output_unit_pkg::POWER_DAC];
		sw.dac_code = word;
		sw.dac_ref_external = cfg.ref_external;
		// The DAC amplifier choice fixes which pin the modulator may use.
		if (dac_live) begin
			pwm_small = cfg.pwm_enable && cfg.dac_amp_large;
			pwm_large = cfg.pwm_enable && !cfg.dac_amp_large;
		end else begin
			pwm_small = cfg.pwm_enable && !cfg.pwm_pin_large;
			pwm_large = cfg.pwm_enable && cfg.pwm_pin_large;
		end
		sw.pwm_to_small = pwm_small;
		sw.pwm_to_large = pwm_large;
		sw.dac_to_large = dac_live && cfg.dac_amp_large && pwr[output_unit_pkg::POWER_LARGE];
		sw.dac_to_small = dac_live && !cfg.dac_amp_large && pwr[output_unit_pkg::POWER_SMALL];
		// An amplifier runs only when powered and its pin is not taken by the modulator.
		sw.small_amp_on = pwr[output_unit_pkg::POWER_SMALL] && !pwm_small;
		sw.large_amp_on = pwr[output_unit_pkg::POWER_LARGE] && !pwm_large;
		// A DAC driver is always a buffer; a free amplifier is a buffer on request.
		sw.small_buffer = sw.small_amp_on && (sw.dac_to_small || cfg.small_buffer);
		sw.large_buffer = sw.large_amp_on && (sw.dac_to_large || cfg.large_buffer);
		// Inverting pin floats in buffer form and whenever the amplifier is off.
		sw.small_inv_hiz = sw.small_buffer || !sw.small_amp_on;
		sw.large_inv_hiz = sw.large_buffer || !sw.large_amp_on;
		route = sw;
	endfunction

	// ----------------------------------------------------------------
	// Register storage.
	// ----------------------------------------------------------------
	logic [15:0] output_unit_data_word [2];
	output_unit_pkg::unit_config_type unit_config [2];
	logic [5:0] power_control;

	// ----------------------------------------------------------------
	// AXI4-Lite write channel.
	// ----------------------------------------------------------------
	logic aw_held;
	logic w_held;
	logic [7:0] aw_index;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic [7:0] write_index;
	logic [31:0] write_data;
	logic [3:0] write_strb;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign write_index = aw_held ? aw_index : reg_index(s_axi_awaddr);
	assign write_data = w_held ? w_data : s_axi_wdata;
	assign write_strb = w_held ? w_strb : s_axi_wstrb;
	assign do_write = (aw_held || (s_axi_awvalid && s_axi_awready)) &&
		(w_held || (s_axi_wvalid && s_axi_wready));

	// Address and data may arrive in either order; each is parked until its partner comes.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_index <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (do_write) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_index <= reg_index(s_axi_awaddr);
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	// Write response follows the cycle in which both halves are present.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= output_unit_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (is_mapped(write_index) && write_index != output_unit_pkg::IDX_STATUS) ?
				output_unit_pkg::RESP_OKAY : output_unit_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register updates; the status word is read-only and writes to it are refused.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			output_unit_data_word[0] <= output_unit_pkg::DATA_RESET;
			output_unit_data_word[1] <= output_unit_pkg::DATA_RESET;
			unit_config[0] <= output_unit_pkg::CONFIG_RESET;
			unit_config[1] <= output_unit_pkg::CONFIG_RESET;
			power_control <= output_unit_pkg::POWER_RESET;
		end else if (do_write) begin
			case (write_index)
				output_unit_pkg::IDX_DATA0: begin
					output_unit_data_word[0] <= 16'(merge(32'(output_unit_data_word[0]), write_data, write_strb));
				end
				output_unit_pkg::IDX_DATA1: begin
					output_unit_data_word[1] <= 16'(merge(32'(output_unit_data_word[1]), write_data, write_strb));
				end
				output_unit_pkg::IDX_CONFIG0: begin
					unit_config[0] <= 7'(merge(32'(unit_config[0]), write_data, write_strb));
				end
				output_unit_pkg::IDX_CONFIG1: begin
					unit_config[1] <= 7'(merge(32'(unit_config[1]), write_data, write_strb));
				end
				output_unit_pkg::IDX_POWER: begin
					power_control <= 6'(merge(32'(power_control), write_data, write_strb));
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Modulator timebase, shared by both units.
	// ----------------------------------------------------------------
	localparam int DIV_WIDTH = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
	localparam logic [DIV_WIDTH-1:0] DIV_LAST = DIV_WIDTH'(STEP_CYCLES - 1);
	logic [DIV_WIDTH-1:0] step_divider;
	logic step_tick;
	logic [11:0] step_count;
	logic period_end;

	assign step_tick = (step_divider == DIV_LAST);
	assign period_end = step_tick && (step_count == output_unit_pkg::PERIOD_LAST);

	// One step enable per step time of clock cycles.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			step_divider <= '0;
		end else if (step_tick) begin
			step_divider <= '0;
		end else begin
			step_divider <= step_divider + 1'b1;
		end
	end

	// Free-running 4096-step period counter; wraps to zero at the period end.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			step_count <= 12'h000;
		end else if (step_tick) begin
			step_count <= step_count + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Per-unit duty latch and pin drive.
	// ----------------------------------------------------------------
	logic [11:0] active_duty [2];
	logic [1:0] pwm_level;

	// Duty is taken over only at the period boundary so no pulse is ever cut short.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			active_duty[0] <= output_unit_pkg::DUTY_OFFSET;
			active_duty[1] <= output_unit_pkg::DUTY_OFFSET;
		end else if (period_end) begin
			active_duty[0] <= duty_of(output_unit_data_word[0]);
			active_duty[1] <= duty_of(output_unit_data_word[1]);
		end
	end

	// High while the step count is below the duty; zero duty never goes high, full is 4095 steps.
	always_comb begin
		for (int u = 0; u < 2; u++) begin
			pwm_level[u] = (step_count < active_duty[u]);
		end
	end

	// Switch controls and pin drive are registered so they never glitch on a register write.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			unit_switches <= '0;
			small_amp_output_pin_out <= 2'h0;
			small_amp_output_pin_oe <= 2'h0;
			large_amp_output_pin_out <= 2'h0;
			large_amp_output_pin_oe <= 2'h0;
		end else begin
			for (int u = 0; u < 2; u++) begin
				unit_switches[u] <= route(unit_config[u],
					power_control[u*output_unit_pkg::POWER_PER_UNIT +: output_unit_pkg::POWER_PER_UNIT],
					output_unit_data_word[u]);
				small_amp_output_pin_oe[u] <= unit_switches[u].pwm_to_small;
				large_amp_output_pin_oe[u] <= unit_switches[u].pwm_to_large;
				small_amp_output_pin_out[u] <= unit_switches[u].pwm_to_small && pwm_level[u];
				large_amp_output_pin_out[u] <= unit_switches[u].pwm_to_large && pwm_level[u];
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel.
	// ----------------------------------------------------------------
	logic [7:0] read_index;
	logic [31:0] status_word;

	assign s_axi_arready = !s_axi_rvalid;
	assign read_index = reg_index(s_axi_araddr);
	// Status shows both live duties, modulator levels and the period position.
	assign status_word = {step_count[11:8], active_duty[1], active_duty[0], 2'h0, pwm_level};

	// A read answers one cycle after its address is taken.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= output_unit_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= is_mapped(read_index) ? output_unit_pkg::RESP_OKAY : output_unit_pkg::RESP_SLVERR;
			case (read_index)
				output_unit_pkg::IDX_DATA0: s_axi_rdata <= 32'(output_unit_data_word[0]);
				output_unit_pkg::IDX_DATA1: s_axi_rdata <= 32'(output_unit_data_word[1]);
				output_unit_pkg::IDX_CONFIG0: s_axi_rdata <= 32'(unit_config[0]);
				output_unit_pkg::IDX_CONFIG1: s_axi_rdata <= 32'(unit_config[1]);
				output_unit_pkg::IDX_STATUS: s_axi_rdata <= status_word;
				output_unit_pkg::IDX_POWER: s_axi_rdata <= 32'(power_control);
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // dac_amp_modulator_unit

/* File: output_load_model.sv */
// Model of the external loads on the modulator pins.
`timescale 1ns/100ps
module output_load_model (
	// Clock.
	input wire logic clk,
	// Modulator drive on both pin pairs.
	input wire logic [1:0] small_out,
	input wire logic [1:0] small_oe,
	input wire logic [1:0] large_out,
	input wire logic [1:0] large_oe,
	// Levels seen by the loads.
	output logic [1:0] small_level,
	output logic [1:0] large_level
);
	logic [1:0] small_last = 2'h0;
	logic [1:0] large_last = 2'h0;
	// No pull on these pins, so a released pin toggles instead of holding a stale level.
	always_ff @(posedge clk) begin
		small_last <= small_level;
		large_last <= large_level;
	end
	assign small_level = (small_oe & small_out) | (~small_oe & ~small_last);
	assign large_level = (large_oe & large_out) | (~large_oe & ~large_last);
endmodule // output_load_model

/* File: output_unit_pkg.sv */
// Constants, register map and carrier types for the dual DAC/modulator output block.
package output_unit_pkg;

	// ----------------------------------------------------------------
	// Register map: printed offsets are word indices, byte address is four times.
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_DATA0 = 8'h00;
	localparam logic [7:0] IDX_DATA1 = 8'h01;
	localparam logic [7:0] IDX_CONFIG0 = 8'h02;
	localparam logic [7:0] IDX_CONFIG1 = 8'h03;
	localparam logic [7:0] IDX_STATUS = 8'h04;
	localparam logic [7:0] IDX_POWER = 8'h31;
	localparam int ADDR_WIDTH = 10;
	localparam int BYTE_SHIFT = 2;

	// ----------------------------------------------------------------
	// Field layout and reset values.
	// ----------------------------------------------------------------
	localparam int DATA_WIDTH = 16;
	localparam int DUTY_WIDTH = 12;
	localparam int DUTY_LOW = 4;
	localparam int CONFIG_WIDTH = 7;
	localparam int POWER_PER_UNIT = 3;
	localparam int POWER_DAC = 0;
	localparam int POWER_SMALL = 1;
	localparam int POWER_LARGE = 2;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [6:0] CONFIG_RESET = 7'h00;
	localparam logic [5:0] POWER_RESET = 6'h00;
	localparam logic [11:0] DUTY_OFFSET = 12'h800;
	localparam logic [11:0] PERIOD_LAST = 12'hFFF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Timing.
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int STEP_TIME_NS = 2000;
	localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;

	// Per-unit configuration word, bit 0 at dac_select.
	typedef struct packed {
		logic ref_external;
		logic large_buffer;
		logic small_buffer;
		logic pwm_pin_large;
		logic dac_amp_large;
		logic pwm_enable;
		logic dac_select;
	} unit_config_type;

	// Analog switch and power controls of one unit.
	typedef struct packed {
		logic [15:0] dac_code;
		logic dac_powered;
		logic dac_ref_external;
		logic dac_to_small;
		logic dac_to_large;
		logic small_amp_on;
		logic large_amp_on;
		logic small_buffer;
		logic large_buffer;
		logic small_inv_hiz;
		logic large_inv_hiz;
		logic pwm_to_small;
		logic pwm_to_large;
	} unit_switch_type;

endpackage

/* File: output_unit_properties.sv */
// Concurrent checks on the ports of the dual output unit block.
`timescale 1ns/100ps
module output_unit_properties #(
	parameter int STEP_CYCLES = 200
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Register bus handshakes.
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Switch controls and modulator pin drive.
	input wire output_unit_pkg::unit_switch_type [1:0] unit_switches,
	input wire logic [1:0] small_amp_output_pin_out,
	input wire logic [1:0] small_amp_output_pin_oe,
	input wire logic [1:0] large_amp_output_pin_out,
	input wire logic [1:0] large_amp_output_pin_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Unit 0 fields, named once to keep the properties readable.
	output_unit_pkg::unit_switch_type u0;
	assign u0 = unit_switches[0];
	// ----------------------------------------------------------------
	// Register bus.
	// ----------------------------------------------------------------
	property p_write_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
	a_write_answer: assert property (p_write_answer) else $error("write answer late");
	property p_resp_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_resp_hold: assert property (p_resp_hold) else $error("write answer dropped");
	property p_read_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_read_hold: assert property (p_read_hold) else $error("read answer dropped");
	// ----------------------------------------------------------------
	// Switch control.
	// ----------------------------------------------------------------
	property p_dac_one_amp; !(u0.dac_to_small && u0.dac_to_large); endproperty
	a_dac_one_amp: assert property (p_dac_one_amp) else $error("dac on both amplifiers");
	property p_large_buffer; u0.dac_to_large |-> u0.large_buffer && u0.large_amp_on && !u0.pwm_to_large; endproperty
	a_large_buffer: assert property (p_large_buffer) else $error("large driver not a buffer");
	property p_pwm_small; u0.pwm_to_small |-> !u0.small_amp_on && !u0.dac_to_small; endproperty
	a_pwm_small: assert property (p_pwm_small) else $error("small pin shared");
	property p_pwm_large; u0.pwm_to_large |-> !u0.large_amp_on && !u0.dac_to_large; endproperty
	a_pwm_large: assert property (p_pwm_large) else $error("large pin shared");
	property p_unpowered; !u0.dac_powered |-> !u0.dac_to_small && !u0.dac_to_large; endproperty
	a_unpowered: assert property (p_unpowered) else $error("unpowered dac routed");
	property p_buffer_hiz; u0.dac_to_small |-> u0.small_buffer && u0.small_amp_on && u0.small_inv_hiz; endproperty
	a_buffer_hiz: assert property (p_buffer_hiz) else $error("small driver not a floating buffer");
	// ----------------------------------------------------------------
	// Modulator pins.
	// ----------------------------------------------------------------
	property p_pin_follows; small_amp_output_pin_oe[1] == $past(unit_switches[1].pwm_to_small); endproperty
	a_pin_follows: assert property (p_pin_follows) else $error("pin drive not routed");
	property p_out_gated; ((small_amp_output_pin_out & ~small_amp_output_pin_oe) |
		(large_amp_output_pin_out & ~large_amp_output_pin_oe)) == 2'h0; endproperty
	a_out_gated: assert property (p_out_gated) else $error("pin level while released");
endmodule // output_unit_properties

bind dac_amp_modulator_unit output_unit_properties #(.STEP_CYCLES(STEP_CYCLES)) output_unit_properties_i (
	.clk(clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.unit_switches(unit_switches), .small_amp_output_pin_out(small_amp_output_pin_out),
	.small_amp_output_pin_oe(small_amp_output_pin_oe), .large_amp_output_pin_out(large_amp_output_pin_out),
	.large_amp_output_pin_oe(large_amp_output_pin_oe)
);

/* File: tb_top.sv */
// Self-checking bench for the dual output unit block.
`timescale 1ns/100ps
module tb_top;
	// ----------------------------------------------------------------
	// Signals, tables and instances.
	// ----------------------------------------------------------------
	localparam int STEP = 2;
	localparam int PERIOD = 4096 * STEP;
	localparam logic [1:0] OK = output_unit_pkg::RESP_OKAY, ER = output_unit_pkg::RESP_SLVERR;
	localparam logic [9:0] A_D0 = 10'h000, A_D1 = 10'h004, A_C0 = 10'h008, A_C1 = 10'h00C, A_ST = 10'h010;
	localparam logic [9:0] A_PW = 10'h0C4;
	logic clk = 1'b0, reset = 1'b1;
	logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	output_unit_pkg::unit_switch_type [1:0] unit_switches;
	logic [1:0] small_amp_output_pin_out, small_amp_output_pin_oe, large_amp_output_pin_out, large_amp_output_pin_oe;
	logic [1:0] small_level, large_level;
	int mismatches = 0, total_checks = 0;
	// Config rows and the expected {dac_s, dac_l, small_on, large_on, pwm_s, pwm_l, small_hiz}.
	logic [6:0] cfg_tab [9] = '{7'h07, 7'h03, 7'h05, 7'h01, 7'h0A, 7'h02, 7'h0F, 7'h15, 7'h41};
	logic [6:0] exp_tab [9] = '{7'h2D, 7'h53, 7'h38, 7'h59, 7'h12, 7'h0D, 7'h2D, 7'h39, 7'h59};
	logic [15:0] d0_tab [3] = '{16'h0000, 16'h800F, 16'h7FFA};
	logic [15:0] d1_tab [3] = '{16'h4007, 16'h7FF3, 16'hC000};
	dac_amp_modulator_unit #(.STEP_CYCLES(STEP)) dac_amp_modulator_unit_i (
		.clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .unit_switches(unit_switches),
		.small_amp_output_pin_out(small_amp_output_pin_out), .small_amp_output_pin_oe(small_amp_output_pin_oe),
		.large_amp_output_pin_out(large_amp_output_pin_out), .large_amp_output_pin_oe(large_amp_output_pin_oe));
	output_load_model output_load_model_i (.clk(clk), .small_out(small_amp_output_pin_out),
		.small_oe(small_amp_output_pin_oe), .large_out(large_amp_output_pin_out), .large_oe(large_amp_output_pin_oe),
		.small_level(small_level), .large_level(large_level));
	// ----------------------------------------------------------------
	// Bus and compare tasks.
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Answer ready is raised with the request and held until the answer is sampled.
	task automatic axi_write(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		check("bresp", {30'h00000000, s_axi_bresp}, {30'h00000000, er});
	endtask
	// The mask leaves out fields that move on their own, such as the period position.
	task automatic rd_check(input string what, input logic [9:0] a, input logic [31:0] e, input logic [1:0] er,
		input logic [31:0] m = 32'hFFFF_FFFF);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		check(what, s_axi_rdata & m, e & m);
		check("rresp", {30'h00000000, s_axi_rresp}, {30'h00000000, er});
	endtask
	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	task automatic test_registers();
		rd_check("data0 reset", A_D0, 32'h0000_0000, OK);
		rd_check("power reset", A_PW, 32'h0000_0000, OK);
		axi_write(A_D0, 32'h1234_ABCD, OK);
		rd_check("data0 width", A_D0, 32'h0000_ABCD, OK);
		check("dac code", {16'h0000, unit_switches[0].dac_code}, 32'h0000_ABCD);
		s_axi_wstrb <= 4'h2;
		axi_write(A_D0, 32'h0000_5600, OK);
		s_axi_wstrb <= 4'hF;
		rd_check("byte strobe", A_D0, 32'h0000_56CD, OK);
		axi_write(A_PW, 32'hFFFF_FFFF, OK);
		rd_check("power width", A_PW, 32'h0000_003F, OK);
		rd_check("unmapped", 10'h014, 32'h0000_0000, ER);
		axi_write(A_ST, 32'h0000_0000, ER);
	endtask
	// Every config row is applied with all circuits powered, then once with power removed.
	task automatic test_routing();
		output_unit_pkg::unit_switch_type s;
		axi_write(A_C1, 32'h0000_0002, OK);
		for (int i = 0; i < 10; i++) begin
			if (i == 9) axi_write(A_PW, 32'h0000_0000, OK);
			axi_write(A_C0, {25'h0000000, cfg_tab[i % 9]}, OK);
			repeat (3) @(posedge clk);
			s = unit_switches[0];
			check("route", {25'h0000000, s.dac_to_small, s.dac_to_large, s.small_amp_on, s.large_amp_on,
				s.pwm_to_small, s.pwm_to_large, s.small_inv_hiz}, {25'h0000000, i == 9 ? 7'h05 : exp_tab[i]});
			check("reference", {31'h00000000, s.dac_ref_external}, {31'h00000000, cfg_tab[i % 9][6]});
			check("dac power", {31'h00000000, s.dac_powered}, {31'h00000000, i != 9});
			check("unit1 route", {31'h00000000, unit_switches[1].pwm_to_small}, 32'h0000_0001);
		end
	endtask
	// High time is counted over one full period after the new word has had a period to latch.
	task automatic test_pwm();
		int hi0;
		int hi1;
		axi_write(A_C0, 32'h0000_000A, OK);
		for (int i = 0; i < 3; i++) begin
			axi_write(A_D0, {16'h0000, d0_tab[i]}, OK);
			axi_write(A_D1, {16'h0000, d1_tab[i]}, OK);
			if (i > 0) rd_check("held duty", A_ST, {4'h0, d1_tab[i - 1][15:4] + 12'h800,
				d0_tab[i - 1][15:4] + 12'h800, 4'h0}, OK, 32'h0FFF_FFF0);
			repeat (PERIOD + 4 * STEP) @(posedge clk);
			hi0 = 0;
			hi1 = 0;
			repeat (PERIOD) begin
				@(negedge clk);
				if (large_level[0] === 1'b1 && large_amp_output_pin_oe[0] === 1'b1) hi0++;
				if (small_level[1] === 1'b1 && small_amp_output_pin_oe[1] === 1'b1) hi1++;
			end
			check("unit0 high", hi0, {20'h00000, d0_tab[i][15:4] + 12'h800} * STEP);
			check("unit1 high", hi1, {20'h00000, d1_tab[i][15:4] + 12'h800} * STEP);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Clock, watchdog and main sequence.
	// ----------------------------------------------------------------
	initial begin
		forever #5 clk = ~clk;
	end
	// The whole run needs about 49000 cycles; a hang is cut off well past that.
	initial begin
		repeat (80000) @(posedge clk);
		mismatches++;
		complete_run();
	end
	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		test_registers();
		test_routing();
		test_pwm();
		complete_run();
	end
endmodule // tb_top
